// ==== rtl/sls_pkg.sv ====
// Package of constants and types for the start-up status LED sequencer
package sls_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned STEP_MS = 500;
  localparam int unsigned TIMEOUT_S = 8;
  localparam longint unsigned STEP_CYCLES = longint'(CLK_HZ) * STEP_MS / 1000;
  localparam longint unsigned TIMEOUT_CYCLES = longint'(CLK_HZ) * TIMEOUT_S;
  localparam int unsigned BASIC_INIT_CYCLES = 16;
  localparam int unsigned FLASH_DIV_LOG2 = 23;

  // ==========================================================
  // Register map (plain port)
  // ==========================================================
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_USER_LED = 4'h2;
  localparam int unsigned CTRL_BUS_DONE = 0;
  localparam int unsigned CTRL_BUS_ERR = 1;
  localparam int unsigned CTRL_LOAD_DONE = 2;
  localparam int unsigned CTRL_INIT_DONE = 3;
  localparam int unsigned CTRL_PROJECT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [11:0] USER_LED_RESET = 12'h000;

  // ==========================================================
  // LED bit positions in the twelve-LED vector
  // ==========================================================
  localparam int unsigned LED_GREEN_A = 0;
  localparam int unsigned LED_RED_A = 1;
  localparam int unsigned LED_RED_B = 3;
  localparam int unsigned LED_GREEN_C = 4;
  localparam int unsigned LED_RED_C = 5;
  localparam int unsigned LED_RED_D = 7;
  localparam int unsigned LED_BLUE = 8;

  // Mode selector encoding
  localparam logic [1:0] SEL_STOP = 2'h0;
  localparam logic [1:0] SEL_RUN = 2'h1;
  localparam logic [1:0] SEL_RESET = 2'h2;

  typedef enum logic [3:0] {
    ST_BASIC = 4'h0,
    ST_WAIT_READY = 4'h1,
    ST_BUS_INIT = 4'h2,
    ST_LOAD = 4'h3,
    ST_POWER_ON = 4'h4,
    ST_STOP = 4'h5,
    ST_INIT = 4'h6,
    ST_RUN = 4'h7
  } sls_state_t;

endpackage

// ==== rtl/sls_tick_if.sv ====
// Interface carrying timer ticks between sequencer and its timer
`timescale 1ns/1ps
interface sls_tick_if;
  logic restart;
  logic step_tick;
  logic timeout;
  modport timer (input restart, output step_tick, output timeout);
  modport seq (output restart, input step_tick, input timeout);
endinterface

// ==== rtl/sls_timer.sv ====
// Step and timeout counters for the start-up sequencer
`timescale 1ns/1ps
module sls_timer #(
  parameter longint unsigned STEP_N = sls_pkg::STEP_CYCLES,
  parameter longint unsigned TOUT_N = sls_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Tick port
  sls_tick_if.timer tk
);
  logic [31:0] step_reg;
  logic [31:0] tout_reg;
  logic timeout_reg;
  wire logic step_end = (step_reg == 32'(STEP_N - 1));
  wire logic tout_end = (tout_reg == 32'(TOUT_N - 1));

  // ==========================================================
  // Counters; restart re-aligns both to a stage start
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (reset || tk.restart)
    begin
      step_reg <= 32'h0000_0000;
      tout_reg <= 32'h0000_0000;
      timeout_reg <= 1'b0;
    end
    else
    begin
      step_reg <= step_end ? 32'h0000_0000 : step_reg + 32'h0000_0001;
      if (!timeout_reg)
        tout_reg <= tout_reg + 32'h0000_0001;
      if (tout_end)
        timeout_reg <= 1'b1;
    end
  end

  assign tk.step_tick = step_end;
  assign tk.timeout = timeout_reg;
endmodule // sls_timer

// ==== rtl/sls_seq.sv ====
// Start-up sequencer with status LEDs and mode selector
// ==========================================================
// Summary of operation
// - Finish basic initialisation, then light the blue indicator.
// - Waiting for ready: blue off, rotate green_a,green_c,red_c,red_a each step.
// - No ready within 8 s lights red_b.
// - After ready, bus init rotates green_a,red_a,red_c,green_c each step.
// - Bus init over 8 s or failing lights red_d.
// - Serial host link enabled in every stage after basic, ready-wait and bus init.
// - Boot project present: load it, flash green_a and red_a.
// - Ready failure blocks user program, raises error, stays stopped.
// - No project: green_c and red_c; stopped with project: red_c only.
// - Init stage: green_c only; running: LEDs follow the user LED register.
// - With red_b lit, never enter running.
// - Bus failure does not block load or run.
// - Running hands all twelve LEDs to the user program.
// - Rotary selector is ignored.
// - Selector: upper is reset, middle stop, bottom run.
// - Start only with selector run and ready received.
// - Reset position resets controller, supply unit and all modules; here the control and user LED registers are cleared only by reset.
// ==========================================================
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module sls_seq #(
  parameter longint unsigned STEP_N = sls_pkg::STEP_CYCLES,
  parameter longint unsigned TOUT_N = sls_pkg::TIMEOUT_CYCLES,
  parameter int unsigned FLASH_LOG2 = sls_pkg::FLASH_DIV_LOG2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // System links
  input wire logic global_ready,
  output logic system_reset,
  output logic host_link_enable,
  output logic controller_error,
  output logic user_program_run,
  // Selectors
  input wire logic [1:0] mode_selector,
  input wire logic [3:0] rotary_selector,
  // Indicators
  output logic [11:0] user_indicator_block,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata
);
  sls_tick_if tk ();
  sls_pkg::sls_state_t state_reg, state_next;
  logic [31:0] ctrl_reg;
  logic [11:0] user_led_reg;
  logic [31:0] rdata_reg;
  logic [3:0] ring_reg;
  logic [4:0] basic_cnt_reg;
  logic [FLASH_LOG2:0] flash_reg;
  logic ready_fail_reg;
  logic bus_fail_reg;
  logic [11:0] led_reg, led_next;

  // ==========================================================
  // Timer
  // ==========================================================
  sls_timer #(.STEP_N(STEP_N), .TOUT_N(TOUT_N)) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .tk(tk)
  );

  // ==========================================================
  // Decodes
  // ==========================================================
  // Rotary selector deliberately unread: reserved position
  wire logic sel_run = (mode_selector == sls_pkg::SEL_RUN);
  wire logic sel_reset = (mode_selector == sls_pkg::SEL_RESET);
  wire logic project = ctrl_reg[sls_pkg::CTRL_PROJECT];
  wire logic bus_done = ctrl_reg[sls_pkg::CTRL_BUS_DONE];
  wire logic bus_err = ctrl_reg[sls_pkg::CTRL_BUS_ERR];
  wire logic load_done = ctrl_reg[sls_pkg::CTRL_LOAD_DONE];
  wire logic init_done = ctrl_reg[sls_pkg::CTRL_INIT_DONE];
  wire logic basic_done = (basic_cnt_reg == 5'(sls_pkg::BASIC_INIT_CYCLES));
  wire logic run_ok = sel_run && !ready_fail_reg;
  wire logic wr_ctrl = reg_write && (reg_addr == sls_pkg::ADDR_CTRL);
  wire logic wr_user = reg_write && (reg_addr == sls_pkg::ADDR_USER_LED);
  wire logic stage_change = (state_next != state_reg);
  wire logic bus_fail_now = bus_err || tk.timeout;
  wire logic [31:0] status_word = {16'h0000, 1'b0, ready_fail_reg, bus_fail_reg,
    host_link_enable, ring_reg, state_reg, led_reg[3:0]};
  wire logic [31:0] rdata_next = (reg_addr == sls_pkg::ADDR_CTRL) ? ctrl_reg :
    (reg_addr == sls_pkg::ADDR_STATUS) ? status_word :
    (reg_addr == sls_pkg::ADDR_USER_LED) ? {20'h00000, user_led_reg} : 32'h0000_0000;

  assign tk.restart = stage_change;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      sls_pkg::ST_BASIC:
        if (basic_done) state_next = sls_pkg::ST_WAIT_READY;
      sls_pkg::ST_WAIT_READY:
        if (global_ready) state_next = sls_pkg::ST_BUS_INIT;
        else if (tk.timeout) state_next = sls_pkg::ST_STOP;
      sls_pkg::ST_BUS_INIT:
        if (bus_done || bus_fail_now)
          state_next = project ? sls_pkg::ST_LOAD : sls_pkg::ST_POWER_ON;
      sls_pkg::ST_LOAD:
        if (load_done) state_next = sls_pkg::ST_STOP;
      sls_pkg::ST_POWER_ON:
        if (project) state_next = sls_pkg::ST_STOP;
      sls_pkg::ST_STOP:
        if (run_ok && project) state_next = sls_pkg::ST_INIT;
      sls_pkg::ST_INIT:
        if (!run_ok) state_next = sls_pkg::ST_STOP;
        else if (init_done) state_next = sls_pkg::ST_RUN;
      sls_pkg::ST_RUN:
        if (!run_ok) state_next = sls_pkg::ST_STOP;
      default:
        state_next = sls_pkg::ST_BASIC;
    endcase
  end

  // ==========================================================
  // LED pattern selection
  // ==========================================================
  always_comb
  begin
    led_next = 12'h000;
    case (state_reg)
      sls_pkg::ST_BASIC:
        led_next = 12'h000;
      sls_pkg::ST_WAIT_READY:
      begin
        // Counter-clockwise ring, blue off
        led_next[sls_pkg::LED_GREEN_A] = ring_reg[0];
        led_next[sls_pkg::LED_GREEN_C] = ring_reg[1];
        led_next[sls_pkg::LED_RED_C] = ring_reg[2];
        led_next[sls_pkg::LED_RED_A] = ring_reg[3];
      end
      sls_pkg::ST_BUS_INIT:
      begin
        led_next[sls_pkg::LED_GREEN_A] = ring_reg[0];
        led_next[sls_pkg::LED_RED_A] = ring_reg[1];
        led_next[sls_pkg::LED_RED_C] = ring_reg[2];
        led_next[sls_pkg::LED_GREEN_C] = ring_reg[3];
      end
      sls_pkg::ST_LOAD:
      begin
        led_next[sls_pkg::LED_GREEN_A] = flash_reg[FLASH_LOG2];
        led_next[sls_pkg::LED_RED_A] = flash_reg[FLASH_LOG2];
      end
      sls_pkg::ST_POWER_ON:
      begin
        led_next[sls_pkg::LED_GREEN_C] = 1'b1;
        led_next[sls_pkg::LED_RED_C] = 1'b1;
      end
      sls_pkg::ST_STOP:
      begin
        // Stopped without project keeps the power-on pair
        led_next[sls_pkg::LED_RED_C] = 1'b1;
        led_next[sls_pkg::LED_GREEN_C] = !project;
      end
      sls_pkg::ST_INIT:
        led_next[sls_pkg::LED_GREEN_C] = 1'b1;
      sls_pkg::ST_RUN:
        led_next = user_led_reg;
      default:
        led_next = 12'h000;
    endcase
    // Blue marks basic init done, dark while waiting for ready
    if (state_reg != sls_pkg::ST_BASIC && state_reg != sls_pkg::ST_WAIT_READY
        && state_reg != sls_pkg::ST_RUN)
      led_next[sls_pkg::LED_BLUE] = 1'b1;
    if (state_reg != sls_pkg::ST_RUN)
    begin
      led_next[sls_pkg::LED_RED_B] = ready_fail_reg;
      led_next[sls_pkg::LED_RED_D] = bus_fail_reg;
    end
  end

  // ==========================================================
  // State, timers and error latches
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (reset || sel_reset)
    begin
      state_reg <= sls_pkg::ST_BASIC;
      basic_cnt_reg <= 5'h00;
      ring_reg <= 4'h1;
      ready_fail_reg <= 1'b0;
      bus_fail_reg <= 1'b0;
      flash_reg <= '0;
      led_reg <= 12'h000;
    end
    else
    begin
      state_reg <= state_next;
      led_reg <= led_next;
      // Free-running divider; its top bit sets the flash rate
      flash_reg <= flash_reg + {{FLASH_LOG2{1'b0}}, 1'b1};
      if (!basic_done)
        basic_cnt_reg <= basic_cnt_reg + 5'h01;
      // One lit LED stepping round; re-armed at every stage start
      if (stage_change)
        ring_reg <= 4'h1;
      else if (tk.step_tick)
        ring_reg <= {ring_reg[2:0], ring_reg[3]};
      if (state_reg == sls_pkg::ST_WAIT_READY && !global_ready && tk.timeout)
        ready_fail_reg <= 1'b1;
      if (state_reg == sls_pkg::ST_BUS_INIT && !bus_done && bus_fail_now)
        bus_fail_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Register port: control, status and user LEDs
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_reg <= sls_pkg::CTRL_RESET;
      user_led_reg <= sls_pkg::USER_LED_RESET;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= reg_wdata;
      if (wr_user)
        user_led_reg <= reg_wdata[11:0];
      rdata_reg <= reg_read ? rdata_next : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign user_indicator_block = led_reg;
  assign reg_rdata = rdata_reg;
  assign system_reset = sel_reset || reset;
  // Host link closed in basic, ready-wait and bus stages, open in every other stage
  assign host_link_enable = (state_reg != sls_pkg::ST_BASIC) &&
    (state_reg != sls_pkg::ST_WAIT_READY) && (state_reg != sls_pkg::ST_BUS_INIT);
  assign controller_error = ready_fail_reg;
  assign user_program_run = (state_reg == sls_pkg::ST_RUN);

  // ==========================================================
  // Checks
  // ==========================================================
  no_run_fail_a: assert property (@(posedge clk_sys) disable iff (reset)
    ready_fail_reg |-> state_reg != sls_pkg::ST_RUN)
    else $error("running with ready failure");
  run_needs_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == sls_pkg::ST_RUN |-> $past(sel_run))
    else $error("run without run selector");
  fail_latched_a: assert property (@(posedge clk_sys) disable iff (reset || sel_reset)
    ready_fail_reg |=> ready_fail_reg)
    else $error("ready failure cleared");
  bus_latched_a: assert property (@(posedge clk_sys) disable iff (reset || sel_reset)
    bus_fail_reg |=> bus_fail_reg)
    else $error("bus failure cleared");
  red_b_shown_a: assert property (@(posedge clk_sys) disable iff (reset || sel_reset)
    $rose(ready_fail_reg) |=> user_indicator_block[sls_pkg::LED_RED_B])
    else $error("red_b not shown");
  link_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == sls_pkg::ST_BUS_INIT |-> !host_link_enable)
    else $error("host link open in bus stage");
  power_on_led_a: assert property (@(posedge clk_sys) disable iff (reset || sel_reset)
    state_reg == sls_pkg::ST_POWER_ON ##1 state_reg == sls_pkg::ST_POWER_ON
    |-> user_indicator_block[5:4] == 2'h3)
    else $error("power-on pattern wrong");
  reset_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
    sel_reset |-> system_reset ##1 state_reg == sls_pkg::ST_BASIC)
    else $error("reset position not obeyed");
  fail_stops_a: assert property (@(posedge clk_sys) disable iff (reset)
    ready_fail_reg |-> state_reg == sls_pkg::ST_STOP)
    else $error("ready failure left stop");
  bus_err_latch_a: assert property (@(posedge clk_sys) disable iff (reset || sel_reset)
    state_reg == sls_pkg::ST_BUS_INIT && !bus_done && bus_err |=> bus_fail_reg)
    else $error("bus error not latched");
  ring_one_hot_a: assert property (@(posedge clk_sys) disable iff (reset)
    $onehot(ring_reg))
    else $error("ring pattern not one-hot");
  wait_blue_off_a: assert property (@(posedge clk_sys) disable iff (reset || sel_reset)
    state_reg == sls_pkg::ST_WAIT_READY ##1 state_reg == sls_pkg::ST_WAIT_READY
    |-> !user_indicator_block[sls_pkg::LED_BLUE])
    else $error("blue lit while waiting");
  init_led_a: assert property (@(posedge clk_sys) disable iff (reset || sel_reset)
    state_reg == sls_pkg::ST_INIT ##1 state_reg == sls_pkg::ST_INIT
    |-> user_indicator_block[sls_pkg::LED_GREEN_C]
    && !user_indicator_block[sls_pkg::LED_GREEN_A])
    else $error("init pattern wrong");
  run_user_led_a: assert property (@(posedge clk_sys) disable iff (reset || sel_reset)
    state_reg == sls_pkg::ST_RUN |=> user_indicator_block == $past(user_led_reg))
    else $error("user LEDs not shown");
endmodule // sls_seq

// ==== test/sls_ready_src.sv ====
// Model of the supply unit and neighbour modules that issue global ready
`timescale 1ns/1ps
module sls_ready_src (
  // Clock and system reset
  input wire logic clk_sys,
  input wire logic system_reset,
  // Behaviour chosen by the bench
  input wire logic [15:0] ready_delay,
  input wire logic never_ready,
  // Ready line towards the controller
  output logic global_ready
);
  logic [15:0] up_cnt_reg;
  // Ready only once operational; a stuck module never gets there
  always_ff @(posedge clk_sys)
  begin
    if (system_reset)
    begin
      up_cnt_reg <= 16'h0000;
      global_ready <= 1'b0;
    end
    else if (up_cnt_reg >= ready_delay)
      global_ready <= ~never_ready;
    else
      up_cnt_reg <= up_cnt_reg + 16'h0001;
  end
endmodule // sls_ready_src

// ==== test/sls_seq_tb.sv ====
// Self-checking bench for the start-up sequencer
`timescale 1ns/1ps
module sls_seq_tb;
  // ==========================================================
  // Signals and constants
  // ==========================================================
  localparam longint unsigned STEP = 64'h8;
  localparam longint unsigned TOUT = 64'h40;
  // Short flash divider: four cycles lit in any eight
  localparam int unsigned FLSH = 2;
  localparam logic [31:0] PRJ = 32'h1 << sls_pkg::CTRL_PROJECT;
  localparam logic [31:0] BDN = 32'h1 << sls_pkg::CTRL_BUS_DONE;
  localparam logic [31:0] BER = 32'h1 << sls_pkg::CTRL_BUS_ERR;
  localparam logic [31:0] LDN = 32'h1 << sls_pkg::CTRL_LOAD_DONE;
  localparam logic [31:0] IDN = 32'h1 << sls_pkg::CTRL_INIT_DONE;
  localparam logic [11:0] GA = 12'h1 << sls_pkg::LED_GREEN_A;
  localparam logic [11:0] RA = 12'h1 << sls_pkg::LED_RED_A;
  localparam logic [11:0] RB = 12'h1 << sls_pkg::LED_RED_B;
  localparam logic [11:0] GC = 12'h1 << sls_pkg::LED_GREEN_C;
  localparam logic [11:0] RC = 12'h1 << sls_pkg::LED_RED_C;
  localparam logic [11:0] RD = 12'h1 << sls_pkg::LED_RED_D;
  localparam logic [11:0] BL = 12'h1 << sls_pkg::LED_BLUE;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic global_ready, system_reset, link, ctrl_err, run;
  logic [1:0] mode_sel = 2'h0;
  logic [3:0] rotary = 4'h0;
  logic [11:0] leds;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata, rd, v;
  int lit_any, lit_both;
  logic [15:0] ready_delay = 16'h10;
  logic never_ready = 1'b1;
  logic [31:0] rng = 32'h7;
  int mismatches = 0;
  int cmp_count = 0;

  sls_seq #(.STEP_N(STEP), .TOUT_N(TOUT), .FLASH_LOG2(FLSH)) DUT (
    .clk_sys(clk_sys), .reset(reset), .global_ready(global_ready),
    .system_reset(system_reset), .host_link_enable(link), .controller_error(ctrl_err),
    .user_program_run(run), .mode_selector(mode_sel), .rotary_selector(rotary),
    .user_indicator_block(leds), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  sls_ready_src u_src (.clk_sys(clk_sys), .system_reset(system_reset),
    .ready_delay(ready_delay), .never_ready(never_ready), .global_ready(global_ready));

  // Clock, and a rotary selector that keeps moving
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    rotary <= 4'(rnd());

  // ==========================================================
  // Helpers
  // ==========================================================
  // Only the rotary process advances the generator, so runs repeat
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk_led(string n, logic [11:0] e, logic [11:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  task automatic sel(logic [1:0] m);
    @(posedge clk_sys);
    mode_sel <= m;
  endtask
  task automatic hard_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
  endtask
  task automatic wait_led(logic [11:0] m, int lim);
    for (int i = 0; i < lim && (leds & m) == 12'h000; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic expect_state(sls_pkg::sls_state_t st);
    rd_reg(sls_pkg::ADDR_STATUS);
    for (int i = 0; i < 100 && rd[7:4] !== st; i++)
      rd_reg(sls_pkg::ADDR_STATUS);
    chk_word("state", 32'(st), {28'h0, rd[7:4]});
  endtask
  // Each change of the lit ring LED must be the next one in s
  task automatic watch_ring(string name, logic [11:0] s[4], logic blue, int cyc);
    logic [11:0] prev, cur, nx;
    int n;
    prev = 12'h000;
    n = 0;
    repeat (cyc)
    begin
      @(posedge clk_sys);
      #1;
      cur = leds & (GA | RA | GC | RC);
      if (cur != prev && prev != 12'h000)
      begin
        nx = (prev == s[0]) ? s[1] : (prev == s[1]) ? s[2] : (prev == s[2]) ? s[3] : s[0];
        chk_led(name, nx, cur);
        n++;
      end
      chk_bit("blue", blue, |(leds & BL));
      prev = cur;
    end
    chk_bit("ring steps", 1'b1, n >= 3);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    // Neighbours never report ready
    wait_led(GA, 60);
    watch_ring("wait ring", '{GA, GC, RC, RA}, 1'b0, 40);
    chk_bit("red_b early", 1'b0, |(leds & RB));
    wait_led(RB, 40);
    chk_bit("red_b", 1'b1, |(leds & RB));
    chk_bit("ctrl error", 1'b1, ctrl_err);
    // Read the generator off the edge, away from the rotary process
    ready_delay <= 16'h10 + 16'(rng[4:0]);
    wr(sls_pkg::ADDR_CTRL, PRJ);
    sel(sls_pkg::SEL_RUN);
    never_ready <= 1'b0;
    repeat (30) @(posedge clk_sys);
    #1;
    chk_bit("run blocked", 1'b0, run);
    chk_bit("red_b held", 1'b1, |(leds & RB));
    expect_state(sls_pkg::ST_STOP);
    // Upper position restarts all but the register port, ready then arrives
    sel(sls_pkg::SEL_RESET);
    @(posedge clk_sys);
    #1;
    chk_bit("sys reset", 1'b1, system_reset);
    sel(sls_pkg::SEL_STOP);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_bit("sys reset off", 1'b0, system_reset);
    chk_bit("red_b clear", 1'b0, |(leds & RB));
    wait_led(BL, 300);
    chk_bit("link early", 1'b0, link);
    watch_ring("bus ring", '{GA, RA, RC, GC}, 1'b1, 36);
    chk_bit("red_d early", 1'b0, |(leds & RD));
    wr(sls_pkg::ADDR_CTRL, PRJ | BDN);
    expect_state(sls_pkg::ST_LOAD);
    // Both flash LEDs lit together for half of each flash period
    lit_any = 0;
    lit_both = 0;
    repeat (8)
    begin
      @(posedge clk_sys);
      #1;
      lit_any += |(leds & (GA | RA));
      lit_both += ((leds & (GA | RA)) == (GA | RA));
    end
    chk_word("flash on", 32'h4, 32'(lit_any));
    chk_word("flash pair", 32'h4, 32'(lit_both));
    chk_bit("link", 1'b1, link);
    wr(sls_pkg::ADDR_CTRL, PRJ | BDN | LDN);
    expect_state(sls_pkg::ST_STOP);
    chk_led("stop leds", RC, leds & 12'h0FF);
    sel(2'h3);
    repeat (20) @(posedge clk_sys);
    #1;
    chk_bit("held stop", 1'b0, run);
    sel(sls_pkg::SEL_RUN);
    expect_state(sls_pkg::ST_INIT);
    chk_led("init leds", GC, leds & 12'h0FF);
    v = rng;
    wr(sls_pkg::ADDR_USER_LED, v);
    wr(sls_pkg::ADDR_CTRL, PRJ | BDN | LDN | IDN);
    expect_state(sls_pkg::ST_RUN);
    chk_bit("run", 1'b1, run);
    chk_led("user leds", v[11:0], leds);
    rd_reg(sls_pkg::ADDR_USER_LED);
    chk_word("user reg", {20'h0, v[11:0]}, rd);
    rd_reg(4'hF);
    chk_word("unmapped", 32'h0, rd);
    @(posedge clk_sys);
    #1;
    chk_word("rdata idle", 32'h0, reg_rdata);
    // Bus stage runs out of time with no project stored
    hard_reset();
    rd_reg(sls_pkg::ADDR_USER_LED);
    chk_word("user reset", {20'h0, sls_pkg::USER_LED_RESET}, rd);
    rd_reg(sls_pkg::ADDR_CTRL);
    chk_word("ctrl reset", sls_pkg::CTRL_RESET, rd);
    wait_led(BL, 300);
    wait_led(RD, 100);
    chk_bit("bus timeout", 1'b1, |(leds & RD));
    expect_state(sls_pkg::ST_POWER_ON);
    chk_led("power on leds", GC | RC | RD, leds & 12'h0FF);
    // Bus error reported, the project still loads and runs
    hard_reset();
    wr(sls_pkg::ADDR_CTRL, PRJ | BER);
    expect_state(sls_pkg::ST_LOAD);
    chk_bit("bus error", 1'b1, |(leds & RD));
    wr(sls_pkg::ADDR_CTRL, PRJ | BER | LDN | IDN);
    expect_state(sls_pkg::ST_RUN);
    chk_bit("run despite bus", 1'b1, run);
    end_sim();
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    #(4 * 20000);
    mismatches++;
    $display("[FAIL] watchdog");
    end_sim();
  end
endmodule // sls_seq_tb
